// ---- verilog/iaf_pkg.sv ----
package iaf_pkg;
  // data address width and pointer count
  localparam int          ADDR_W     = 12;
  localparam int          NPTR       = 3;
  // virtual port group: plain port of pointer n sits at base minus n times stride
  localparam logic [11:0] PORT_BASE0 = 12'hfef;
  localparam logic [11:0] PTR_STRIDE = 12'h008;
  localparam logic [11:0] GRP_SIZE   = 12'h007;
  // offsets below the plain port inside one group
  localparam logic [2:0]  SEL_PLAIN  = 3'h0;
  localparam logic [2:0]  SEL_PINC   = 3'h1;
  localparam logic [2:0]  SEL_PDEC   = 3'h2;
  localparam logic [2:0]  SEL_PREINC = 3'h3;
  localparam logic [2:0]  SEL_INDEX  = 3'h4;
  localparam logic [2:0]  SEL_HIGH   = 3'h5;
  localparam logic [2:0]  SEL_LOW    = 3'h6;
  // other special addresses
  localparam logic [11:0] STATUS_ADDR = 12'hfd8;
  localparam logic [11:0] ACC_ADDR    = 12'hfe8;
  // flag positions in alu_condition_flags
  localparam int FLG_C  = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N  = 4;
  // flag masks per operation class
  localparam logic [4:0] M_ALL = 5'h1f;
  localparam logic [4:0] M_NZ  = 5'h14;
  localparam logic [4:0] M_ROT = 5'h17;
  // reset values
  localparam logic [11:0] PTR_RST  = 12'h000;
  localparam logic [4:0]  STAT_RST = 5'h00;
  localparam logic [7:0]  ACC_RST  = 8'h00;
  // axi4-lite register byte offsets
  localparam logic [7:0] REG_PTR0 = 8'h00;
  localparam logic [7:0] REG_PTR1 = 8'h04;
  localparam logic [7:0] REG_PTR2 = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_ACC  = 8'h10;
  localparam logic [7:0] REG_LAST = 8'h14;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // core operations, one-hot
  typedef enum logic [5:0] {
    OP_MOVE = 6'h01, OP_ADD = 6'h02, OP_SUB = 6'h04,
    OP_AND  = 6'h08, OP_RLC = 6'h10, OP_RRC = 6'h20
  } iaf_op_t;
  // core request and answer
  typedef struct packed {
    logic valid; logic we; iaf_op_t op; logic [11:0] addr; logic [7:0] wdata;
  } iaf_req_t;
  typedef struct packed {logic valid; logic [7:0] rdata;} iaf_rsp_t;
  // port decode and alu outcome
  typedef struct packed {logic hit; logic [1:0] idx; logic [2:0] sel;} iaf_dec_t;
  typedef struct packed {logic [7:0] r; logic [4:0] f; logic [4:0] m;} iaf_alu_t;
endpackage

// ---- verilog/iaf_core.sv ----
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// [R1] three pointers, high and low byte joined
// [R2] port access redirects to pointed location
// [R3] indirect read of port returns zero, sets Z
// [R4] indirect write of port is no-op
// [R5] five ports per pointer; plain leaves pointer
// [R6] post-decrement: use pointer, then minus one
// [R7] post-increment: use pointer, then plus one
// [R8] pre-increment: plus one, then use it
// [R9] indexed: pointer plus signed accumulator, no change
// [R10] pointer stepping never touches flags
// [R11] stepping carries across full twelve bits
// [R12] write to pointer byte beats stepping
// [R13] flag-setting result to status keeps computed flags
// [R14] status bits 7..5 zero; N OV Z DC C
// [R15] N follows result bit seven
// [R16] OV set on signed overflow
// [R17] Z set when result is zero
// [R18] DC is carry out of low nibble
// [R19] C is carry out of bit seven
// [R20] subtract adds two's complement; inverted borrow
// [R21] rotate loads DC and C from source bits
// [R22] address sums wrap at twelve bits
module iaf_core
  import iaf_pkg::*;
#(
  parameter int DEPTH = 4096
)(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // core access port
  input  wire iaf_req_t    req,
  output iaf_rsp_t         rsp,
  output logic [4:0]       flags,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  // finds which pointer group and port an address hits
  function automatic iaf_dec_t port_dec(logic [11:0] a);
    logic [11:0] d;
    iaf_dec_t    o;
    o = '0;
    for (int i = 0; i < NPTR; i++) begin
      d = PORT_BASE0 - PTR_STRIDE * 12'(i) - a;
      if (d < GRP_SIZE) begin
        o.hit = 1'b1;
        o.idx = 2'(i);
        o.sel = d[2:0];
      end
    end
    return o;
  endfunction

  // arithmetic with flag outcome and mask of flags it owns
  function automatic iaf_alu_t alu_f(iaf_op_t op, logic [7:0] a, logic [7:0] b, logic c);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] bb;
    iaf_alu_t   o;
    o  = '0;
    bb = (op == OP_SUB) ? ~b : b; // R20
    s  = {1'b0, a} + {1'b0, bb} + {8'h00, op == OP_SUB};
    h  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, op == OP_SUB};
    case (op)
      OP_ADD, OP_SUB: begin
        o.r         = s[7:0];
        o.f[FLG_C]  = s[8]; // R19
        o.f[FLG_DC] = h[4]; // R18
        o.f[FLG_OV] = (a[7] == bb[7]) && (s[7] != a[7]); // R16
        o.m         = M_ALL;
      end
      OP_AND: begin
        o.r = a & b;
        o.m = M_NZ;
      end
      OP_RLC: begin
        o.r         = {a[6:0], c};
        o.f[FLG_C]  = a[7]; // R21
        o.f[FLG_DC] = a[3]; // R21
        o.m         = M_ROT;
      end
      OP_RRC: begin
        o.r         = {c, a[7:1]};
        o.f[FLG_C]  = a[0]; // R21
        o.f[FLG_DC] = a[4]; // R21
        o.m         = M_ROT;
      end
      default: begin
        o.r = a;
        o.m = 5'h00;
      end
    endcase
    o.f[FLG_N] = o.r[7]; // R15
    o.f[FLG_Z] = (o.r == 8'h00); // R17
    return o;
  endfunction

  // state
  logic [11:0] ptr_r [NPTR];     // R1
  logic [4:0]  status_r;         // five flags only, upper bits absent
  logic [7:0]  acc_r;            // working_accumulator
  logic [11:0] last_r;           // last effective address
  logic [7:0]  ram [DEPTH];      // data memory
  // axi holding registers
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;

  // decode of the current access
  iaf_dec_t    pd, td;
  iaf_alu_t    alu;
  logic        is_ind, guard, commit, sfr;
  logic [11:0] base, inc, dec, idxd, ea, tgt;
  logic [7:0]  rdval;

  // address generation for the current request
  always_comb begin
    pd     = port_dec(req.addr);
    is_ind = req.valid && pd.hit && (pd.sel <= SEL_INDEX); // R2
    base   = ptr_r[pd.idx];
    inc    = base + 12'h001; // R11 R22
    dec    = base - 12'h001; // R11 R22
    idxd   = base + {{4{acc_r[7]}}, acc_r}; // R9 R22
    case (pd.sel)
      SEL_PREINC: ea = inc;  // R8
      SEL_INDEX:  ea = idxd; // R9
      default:    ea = base; // R5 R6 R7
    endcase
    tgt   = is_ind ? ea : req.addr; // R2
    td    = port_dec(tgt);
    guard = is_ind && td.hit && (td.sel <= SEL_INDEX);
    sfr   = td.hit || (tgt == STATUS_ADDR) || (tgt == ACC_ADDR);
    alu   = alu_f(req.op, req.wdata, acc_r, status_r[FLG_C]);
    // read data from the resolved target
    if (td.hit && td.sel == SEL_HIGH) rdval = {4'h0, ptr_r[td.idx][11:8]};
    else if (td.hit && td.sel == SEL_LOW) rdval = ptr_r[td.idx][7:0];
    else if (tgt == STATUS_ADDR) rdval = {3'h0, status_r}; // R14
    else if (tgt == ACC_ADDR) rdval = acc_r;
    else if (td.hit) rdval = 8'h00;
    else rdval = ram[tgt];
  end

  // software writes wait for a cycle with no core access, so no clash
  assign commit = !awready && !wready && !bvalid && !req.valid;

  // pointers: stepping, then byte writes on top
  always_ff @(posedge aclk) begin
    for (int i = 0; i < NPTR; i++) begin
      if (!aresetn) begin
        ptr_r[i] <= PTR_RST;
      end else if (commit && aw_addr_r == REG_PTR0 + 8'(4 * i)) begin
        if (w_strb_r[0]) ptr_r[i][7:0] <= w_data_r[7:0];
        if (w_strb_r[1]) ptr_r[i][11:8] <= w_data_r[11:8];
      end else if (req.valid) begin
        // step first, a byte write below overrides it
        if (is_ind && pd.idx == 2'(i)) begin
          case (pd.sel)
            SEL_PINC, SEL_PREINC: ptr_r[i] <= inc; // R7 R8 R11
            SEL_PDEC:             ptr_r[i] <= dec; // R6 R11
            default:              ptr_r[i] <= base; // R5 R9
          endcase
        end
        if (req.we && !guard && td.hit && td.idx == 2'(i)) begin
          if (td.sel == SEL_HIGH) ptr_r[i][11:8] <= alu.r[3:0]; // R12
          if (td.sel == SEL_LOW) ptr_r[i][7:0] <= alu.r; // R12
        end
      end
    end
  end

  // flags: guard cases first, then computed flags, then plain writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= STAT_RST;
    end else if (commit && aw_addr_r == REG_STAT && w_strb_r[0]) begin
      status_r <= w_data_r[4:0];
    end else if (req.valid && guard) begin
      if (!req.we) status_r[FLG_Z] <= 1'b1; // R3; writes leave all, R4
    end else if (req.valid && req.we) begin
      // pointer stepping has no path here at all
      for (int b = 0; b < 5; b++) begin
        if (alu.m[b]) status_r[b] <= alu.f[b]; // R13
        else if (tgt == STATUS_ADDR) status_r[b] <= alu.r[b]; // R13 R14
      end
    end
  end

  // accumulator and last address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r  <= ACC_RST;
      last_r <= 12'h000;
    end else if (commit && aw_addr_r == REG_ACC && w_strb_r[0]) begin
      acc_r <= w_data_r[7:0];
    end else if (req.valid) begin
      last_r <= tgt;
      if (req.we && !guard && tgt == ACC_ADDR) acc_r <= alu.r;
    end
  end

  // memory has no reset, it is plain storage
  always_ff @(posedge aclk) begin
    if (req.valid && req.we && !guard && !sfr) ram[tgt] <= alu.r; // R2
  end

  // core answer one cycle after the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.valid;
      rsp.rdata <= guard ? 8'h00 : rdval; // R3
    end
  end
  assign flags = status_r;

  // axi write channel: latch address and data, answer after commit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= RESP_OK;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_addr_r <= awaddr;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready   <= 1'b0;
      end
      if (commit) begin
        bvalid <= 1'b1;
        // the last-address register is read only
        bresp  <= (aw_addr_r <= REG_ACC && aw_addr_r[1:0] == 2'h0) ? RESP_OK : RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // axi read channel: one cycle to data, held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OK;
      case (araddr)
        REG_PTR0: rdata <= {20'h00000, ptr_r[0]};
        REG_PTR1: rdata <= {20'h00000, ptr_r[1]};
        REG_PTR2: rdata <= {20'h00000, ptr_r[2]};
        REG_STAT: rdata <= {27'h0, status_r};
        REG_ACC:  rdata <= {24'h000000, acc_r};
        REG_LAST: rdata <= {20'h00000, last_r};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_ERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // checks
  logic step_ok;
  assign step_ok = is_ind && !(req.we && td.hit && td.idx == pd.idx);

  property p_post_inc;
    @(posedge aclk) disable iff (!aresetn)
      step_ok && pd.sel == SEL_PINC |=> ptr_r[$past(pd.idx)] == $past(base) + 12'h001;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post-increment wrong"); // R7

  property p_post_dec;
    @(posedge aclk) disable iff (!aresetn)
      step_ok && pd.sel == SEL_PDEC |=> ptr_r[$past(pd.idx)] == $past(base) - 12'h001;
  endproperty
  a_post_dec: assert property (p_post_dec) else $error("post-decrement wrong"); // R6

  property p_keep;
    @(posedge aclk) disable iff (!aresetn)
      step_ok && (pd.sel == SEL_PLAIN || pd.sel == SEL_INDEX)
      |=> ptr_r[$past(pd.idx)] == $past(base);
  endproperty
  a_keep: assert property (p_keep) else $error("pointer moved"); // R5

  property p_pre_addr;
    @(posedge aclk) disable iff (!aresetn)
      is_ind && pd.sel == SEL_PREINC |-> tgt == base + 12'h001;
  endproperty
  a_pre_addr: assert property (p_pre_addr) else $error("pre-increment address wrong"); // R8

  property p_guard_rd;
    @(posedge aclk) disable iff (!aresetn)
      guard && !req.we |=> rsp.valid && rsp.rdata == 8'h00 && status_r[FLG_Z];
  endproperty
  a_guard_rd: assert property (p_guard_rd) else $error("guarded read not zero"); // R3

  property p_guard_wr;
    @(posedge aclk) disable iff (!aresetn)
      guard && req.we |=> $stable(status_r);
  endproperty
  a_guard_wr: assert property (p_guard_wr) else $error("guarded write touched flags"); // R4

  property p_no_step_flags;
    @(posedge aclk) disable iff (!aresetn)
      is_ind && !guard && !req.we |=> $stable(status_r);
  endproperty
  a_no_step_flags: assert property (p_no_step_flags) else $error("flags moved on step"); // R10

  property p_add_carry;
    @(posedge aclk) disable iff (!aresetn)
      req.valid && req.we && !guard && req.op == OP_ADD
      |=> status_r[FLG_C] == $past(req.wdata[7] & acc_r[7] | (req.wdata[7] ^ acc_r[7]) & ~alu.r[7]);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("carry wrong"); // R19

  property p_stat_dest;
    @(posedge aclk) disable iff (!aresetn)
      req.valid && req.we && !guard && tgt == STATUS_ADDR && req.op == OP_ADD
      |=> status_r[FLG_Z] == ($past(alu.r) == 8'h00);
  endproperty
  a_stat_dest: assert property (p_stat_dest) else $error("status write beat flags"); // R13

  c_guard: cover property (@(posedge aclk) disable iff (!aresetn) guard);
  c_wrap: cover property (@(posedge aclk) disable iff (!aresetn) is_ind && base == 12'hfff);
  c_own: cover property (@(posedge aclk) disable iff (!aresetn) step_ok == 1'b0 && is_ind);

endmodule // iaf_core

// ---- tb/iaf_core_model.sv ----
`timescale 1ns/1ps
// core execution path: one access per call, idle cycle after it
module iaf_core_model
  import iaf_pkg::*;
(
  // clock
  input  wire logic     aclk,
  // core side
  output iaf_req_t      req,
  input  wire iaf_rsp_t rsp
);
  // idle until the bench asks for an access
  initial req = '0;
  // answer is looked at mid-cycle, after the take edge has landed
  task automatic access(input logic we, input iaf_op_t op, input logic [11:0] a,
                        input logic [7:0] d, output logic [7:0] rd, output logic ok);
    @(posedge aclk);
    req <= '{valid: 1'b1, we: we, op: op, addr: a, wdata: d};
    @(posedge aclk);
    req.valid <= 1'b0;
    @(negedge aclk);
    ok = rsp.valid;
    rd = rsp.rdata;
  endtask
endmodule // iaf_core_model

// ---- tb/iaf_tb_top.sv ----
`timescale 1ns/1ps
module indirect_addressing_status_flags_tb_top import iaf_pkg::*;;
  // clock, reset and ports
  logic        aclk, aresetn;
  iaf_req_t    req;
  iaf_rsp_t    rsp;
  logic [4:0]  flags;
  logic [7:0]  awaddr, araddr, rd;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ok;
  // counters
  int          fails, total_checks, cyc;

  iaf_core u_iaf_core (.aclk(aclk), .aresetn(aresetn), .req(req), .rsp(rsp), .flags(flags),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  iaf_core_model u_iaf_core_model (.aclk(aclk), .req(req), .rsp(rsp));

  // 200 mhz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // hang guard, well above the expected run
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // port address of pointer n, offset s below its plain port
  function automatic logic [11:0] pa(input int n, input logic [2:0] s);
    return PORT_BASE0 - PTR_STRIDE * 12'(n) - 12'(s);
  endfunction

  // axi4-lite write; handshakes judged at negedge, released after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      r = bresp;
      if (bvalid === 1'b1) break;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  // axi4-lite read; rready held until rvalid is sampled
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hs;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      hs = arvalid && arready;
      d = rdata;
      r = rresp;
      if (rvalid === 1'b1) break;
      @(posedge aclk);
      if (hs) arvalid <= 1'b0;
    end
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // one core access, answer pulse checked each time
  task automatic acc(input logic we, input iaf_op_t op, input logic [11:0] a,
                     input logic [7:0] d);
    u_iaf_core_model.access(we, op, a, d, rd, ok);
    chk("answer pulse", ok, 1);
  endtask

  task automatic t_reset();
    rdr(REG_PTR0, rv, rs);
    chk("pointer0 reset", rv, 0);
    chk("read resp", rs, RESP_OK);
    rdr(REG_STAT, rv, rs);
    chk("status reset", rv, 0);
    chk("flags reset", flags, 0);
    $display("done reset");
  endtask

  // all five ports of pointer 0, byte carry and borrow
  task automatic t_modes();
    wr(REG_PTR0, 32'h100, rs);
    chk("write resp", rs, RESP_OK);
    acc(1, OP_MOVE, pa(0, SEL_PDEC), 8'ha5);
    rdr(REG_PTR0, rv, rs);
    chk("after post-dec", rv, 32'h0ff);
    acc(0, OP_MOVE, pa(0, SEL_PREINC), 8'h00);
    chk("pre-inc data", rd, 8'ha5);
    acc(0, OP_MOVE, pa(0, SEL_PLAIN), 8'h00);
    chk("plain data", rd, 8'ha5);
    rdr(REG_PTR0, rv, rs);
    chk("after plain", rv, 32'h100);
    wr(REG_ACC, 32'hff, rs);
    acc(1, OP_MOVE, pa(0, SEL_INDEX), 8'h3c);
    acc(0, OP_MOVE, pa(0, SEL_PINC), 8'h00);
    chk("post-inc data", rd, 8'ha5);
    rdr(REG_PTR0, rv, rs);
    chk("after post-inc", rv, 32'h101);
    wr(REG_PTR0, 32'h0ff, rs);
    acc(0, OP_MOVE, pa(0, SEL_PLAIN), 8'h00);
    chk("indexed target", rd, 8'h3c);
    rdr(REG_ACC, rv, rs);
    chk("acc kept", rv, 32'hff);
    chk("flags kept", flags, 0);
    $display("done modes");
  endtask

  // pointer 1 aimed at a virtual port
  task automatic t_guard();
    wr(REG_PTR1, 32'(pa(0, SEL_PLAIN)), rs);
    acc(0, OP_MOVE, pa(1, SEL_PLAIN), 8'h00);
    chk("guarded read", rd, 0);
    chk("guarded z", flags, 5'h04);
    acc(1, OP_ADD, pa(1, SEL_PLAIN), 8'h01);
    chk("guarded write", flags, 5'h04);
    $display("done guard");
  endtask

  // operand table, result read back from ram; carry chains across rows
  task automatic t_alu();
    iaf_op_t    op[7] = '{OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_RLC, OP_RRC, OP_AND};
    logic [7:0] a[7]  = '{8'h7f, 8'hff, 8'h05, 8'h03, 8'h88, 8'h11, 8'hf0};
    logic [7:0] b[7]  = '{8'h01, 8'h01, 8'h03, 8'h05, 8'h00, 8'h00, 8'h0f};
    logic [7:0] r[7]  = '{8'h80, 8'h00, 8'h02, 8'hfe, 8'h10, 8'h88, 8'h00};
    logic [4:0] f[7]  = '{5'h1a, 5'h07, 5'h03, 5'h10, 5'h03, 5'h13, 5'h07};
    for (int i = 0; i < 7; i++) begin
      wr(REG_ACC, 32'(b[i]), rs);
      acc(1, op[i], 12'h020, a[i]);
      chk("alu flags", flags, f[i]);
      acc(0, OP_MOVE, 12'h020, 8'h00);
      chk("alu result", rd, r[i]);
    end
    $display("done alu");
  endtask

  // flag-setting result aimed at the status register
  task automatic t_stat();
    wr(REG_ACC, 32'h01, rs);
    acc(1, OP_ADD, STATUS_ADDR, 8'h7f);
    chk("status dest", flags, 5'h1a);
    rdr(REG_STAT, rv, rs);
    chk("status word", rv, 32'h1a);
    acc(0, OP_MOVE, STATUS_ADDR, 8'h00);
    chk("status byte", rd, 8'h1a);
    $display("done status");
  endtask

  // pointer 2 writes its own low byte through post-inc
  task automatic t_self();
    // pointer stepped down to zero must leave z alone
    wr(REG_PTR2, 32'h001, rs);
    acc(0, OP_MOVE, pa(2, SEL_PDEC), 8'h00);
    rdr(REG_PTR2, rv, rs);
    chk("pointer at zero", rv, 32'h000);
    chk("z kept at zero", flags, 5'h1a);
    wr(REG_PTR2, 32'(pa(2, SEL_LOW)), rs);
    acc(1, OP_MOVE, pa(2, SEL_PINC), 8'h40);
    rdr(REG_PTR2, rv, rs);
    chk("self write", rv, {20'h0, pa(2, SEL_LOW) & 12'hf00} | 32'h40);
    acc(0, OP_MOVE, pa(2, SEL_HIGH), 8'h00);
    chk("high byte read", rd, 8'h0f);
    rdr(REG_LAST, rv, rs);
    chk("last address", rv, 32'(pa(2, SEL_HIGH)));
    $display("done self");
  endtask

  // unmapped read, read-only write
  task automatic t_bus();
    rdr(8'h18, rv, rs);
    chk("unmapped resp", rs, RESP_ERR);
    chk("unmapped data", rv, 0);
    wr(REG_LAST, 32'h0, rs);
    chk("ro write resp", rs, RESP_ERR);
    $display("done bus");
  endtask

  initial begin
    {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, fails, total_checks, cyc} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_modes();
    t_guard();
    t_alu();
    t_stat();
    t_self();
    t_bus();
    conclude();
  end
endmodule // indirect_addressing_status_flags_tb_top
